// ### rail_ramp_consts.vh
// Constants for the rail set-point and ramp control block.
// Assumes a 200 MHz reference clock and an 8-bit register port from the serial slave.
`ifndef RAIL_RAMP_CONSTS_VH
`define RAIL_RAMP_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CORE_BUCK_A    8'h16
`define ADDR_CORE_BUCK_B    8'h17
`define ADDR_BUCKBOOST      8'h19
`define ADDR_RAMP_CTRL      8'h1a
`define ADDR_LINEAR_REG     8'h1b

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_CORE_CODE       6'h08
`define RST_BUCKBOOST_CODE  6'h32
`define RST_LINEAR_CODE     6'h1f
`define RST_RAMP_RATE       3'h6
`define RST_SKIP_EN         1'b1

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_TRIGGER         7
`define BIT_AUTO_APPLY      6
`define BIT_SKIP_EN         7
`define CODE_MSB            5
`define RATE_MSB            2

// ----------------------------------------
// Codes and decode constants
// ----------------------------------------
`define RATE_IMMEDIATE      3'h7
`define RATE_FASTEST        3'h6
`define BB_MAX_CODE         6'h34
`define BB_KNEE_CODE        6'h0f
`define BB_BASE_MV          12'h497
`define BB_KNEE_MV          12'h60e
`define LR_KNEE_CODE        6'h1a
`define LR_BASE_MV          12'h384
`define LR_KNEE_MV          12'h60e
`define FINE_STEP_MV        12'h019
`define COARSE_STEP_MV      12'h032

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_PERIOD_PS       5000
`define BASE_TICK_PS        2500000
`define BASE_TICK_CYCLES    (`BASE_TICK_PS / `CLK_PERIOD_PS)
`define BLANK_TIME_MS       5
// Scaled in ns so the product stays inside 32-bit integer arithmetic
`define BLANK_CYCLES        ((`BLANK_TIME_MS * 1000000) / (`CLK_PERIOD_PS / 1000))

`endif

// ### rail_setpoint_ramp_control.v
// Set-point registers, decode, monitor blanking and core-rail ramping.
// Assumes the serial slave presents one-cycle register strobes on this clock,
// and that the unlock level comes from password logic on the same clock.
`timescale 1ns/1ps
`include "rail_ramp_consts.vh"

//Contract
// R1 - Decode buck-boost code, 34h top, rest reserved
// R2 - Trigger write of one starts core ramp
// R3 - Trigger bit self-clears when ramp completes
// R4 - Auto-apply ramps on every core set-point write
// R5 - Rate code sets step spacing, 160 to 2.5us
// R6 - Rate code seven applies set-point at once
// R7 - Only the two core bucks are ramped
// R8 - Host clears skip enable before lowering
// R9 - Linear regulator write blanks monitors 5ms
// R10 - Linear regulator writes need unlock
// R11 - Decode linear regulator code from 0.900V
// R12 - Buck-boost write blanks monitors, needs unlock
// R13 - Host avoids reserved buck-boost codes
// R14 - Ramp moves one code per step interval
// R15 - Ramp control bits 5 to 3 read zero
module rail_setpoint_ramp_control #(
  parameter BLANK_CYCLES = `BLANK_CYCLES  // Monitor blanking length in clocks
) (
  input  wire        i_ref_clk,
  input  wire        i_reset_n,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  input  wire [7:0]  i_reg_addr,
  input  wire [7:0]  i_reg_wdata,
  input  wire        i_unlock,
  output reg  [7:0]  o_reg_rdata,
  output reg  [5:0]  o_core_buck_a_code,
  output reg  [5:0]  o_core_buck_b_code,
  output wire        o_core_buck_a_skip_en,
  output wire        o_core_buck_b_skip_en,
  output reg  [5:0]  o_buckboost_code,
  output reg  [11:0] o_buckboost_mv,
  output reg         o_buckboost_reserved,
  output wire        o_buckboost_skip_en,
  output reg  [5:0]  o_linear_code,
  output reg  [11:0] o_linear_mv,
  output wire        o_buckboost_monitor_blank,
  output wire        o_linear_monitor_blank,
  output wire        o_ramp_busy
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  reg        trigger_ff;       // Transition in progress
  reg        auto_apply_ff;    // Ramp on every core set-point write
  reg  [2:0] rate_ff;          // Step spacing code
  reg  [5:0] target_a_ff;      // Stored core buck A set-point
  reg  [5:0] target_b_ff;      // Stored core buck B set-point
  reg        skip_a_ff;        // Light-load skip enable, core A
  reg        skip_b_ff;        // Light-load skip enable, core B
  reg        skip_bb_ff;       // Light-load skip enable, buck-boost
  reg  [5:0] bb_code_ff;       // Buck-boost set-point
  reg  [5:0] lr_code_ff;       // Linear regulator set-point
  reg  [8:0] tick_cnt_ff;      // Base tick divider
  reg  [6:0] step_cnt_ff;      // Ticks elapsed in this step
  reg  [19:0] bb_blank_ff;     // Buck-boost blanking countdown
  reg  [19:0] lr_blank_ff;     // Linear regulator blanking countdown

  // Write strobes per register
  wire wr_ramp = i_reg_wr && (i_reg_addr == `ADDR_RAMP_CTRL);
  wire wr_a    = i_reg_wr && (i_reg_addr == `ADDR_CORE_BUCK_A);
  wire wr_b    = i_reg_wr && (i_reg_addr == `ADDR_CORE_BUCK_B);
  wire wr_bb   = i_reg_wr && (i_reg_addr == `ADDR_BUCKBOOST) && i_unlock;  // see R12
  wire wr_lr   = i_reg_wr && (i_reg_addr == `ADDR_LINEAR_REG) && i_unlock; // see R10

  // Ramp start sources: explicit trigger or auto-apply on set-point write
  wire go_write   = wr_ramp && i_reg_wdata[`BIT_TRIGGER];              // see R2
  wire auto_start = auto_apply_ff && (wr_a || wr_b);                   // see R4
  wire start      = go_write || auto_start;

  // Ticks per step: 1 at the fastest code, doubling per code down to 64
  wire [6:0] ticks_per_step = 7'h01 << (`RATE_FASTEST - rate_ff);     // see R5
  wire       base_tick  = (tick_cnt_ff == (`BASE_TICK_CYCLES - 1));
  wire       step_due   = base_tick && (step_cnt_ff == (ticks_per_step - 7'h01));
  wire       at_target  = (o_core_buck_a_code == target_a_ff) && (o_core_buck_b_code == target_b_ff);
  wire       immediate  = (rate_ff == `RATE_IMMEDIATE);

  assign o_ramp_busy               = trigger_ff;
  assign o_core_buck_a_skip_en     = skip_a_ff;
  assign o_core_buck_b_skip_en     = skip_b_ff;
  assign o_buckboost_skip_en       = skip_bb_ff;
  assign o_buckboost_monitor_blank = (bb_blank_ff != 20'h0_0000);
  assign o_linear_monitor_blank    = (lr_blank_ff != 20'h0_0000);

  // One code toward the target; never overshoots
  function [5:0] step_toward;
    input [5:0] cur;
    input [5:0] tgt;
    begin
      if (cur < tgt) begin
        step_toward = cur + 6'h01;
      end else if (cur > tgt) begin
        step_toward = cur - 6'h01;
      end else begin
        step_toward = cur;
      end
    end
  endfunction

  // ----------------------------------------
  // Control and set-point registers
  // ----------------------------------------
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      auto_apply_ff <= 1'b0;
      rate_ff       <= `RST_RAMP_RATE;
      target_a_ff   <= `RST_CORE_CODE;
      target_b_ff   <= `RST_CORE_CODE;
      skip_a_ff     <= `RST_SKIP_EN;
      skip_b_ff     <= `RST_SKIP_EN;
      skip_bb_ff    <= `RST_SKIP_EN;
      bb_code_ff    <= `RST_BUCKBOOST_CODE;
      lr_code_ff    <= `RST_LINEAR_CODE;
    end else begin
      // Reserved bits 5..3 are simply not stored
      if (wr_ramp) begin
        auto_apply_ff <= i_reg_wdata[`BIT_AUTO_APPLY];                // see R4
        rate_ff       <= i_reg_wdata[`RATE_MSB:0];                    // see R15
      end
      // Skip enable is host-managed before lowering a rail
      if (wr_a) begin
        target_a_ff <= i_reg_wdata[`CODE_MSB:0];
        skip_a_ff   <= i_reg_wdata[`BIT_SKIP_EN];                     // see R8
      end
      if (wr_b) begin
        target_b_ff <= i_reg_wdata[`CODE_MSB:0];
        skip_b_ff   <= i_reg_wdata[`BIT_SKIP_EN];                     // see R8
      end
      // Reserved codes are stored as written; flagged, not blocked
      if (wr_bb) begin
        bb_code_ff <= i_reg_wdata[`CODE_MSB:0];                       // see R13
        skip_bb_ff <= i_reg_wdata[`BIT_SKIP_EN];
      end
      if (wr_lr) begin
        lr_code_ff <= i_reg_wdata[`CODE_MSB:0];                       // see R10
      end
    end
  end

  // ----------------------------------------
  // Core rail ramp engine
  // ----------------------------------------
  // Only the core bucks go through here; other rails follow their register directly
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      trigger_ff         <= 1'b0;
      o_core_buck_a_code <= `RST_CORE_CODE;
      o_core_buck_b_code <= `RST_CORE_CODE;
      tick_cnt_ff        <= 9'h000;
      step_cnt_ff        <= 7'h00;
    end else begin
      if (start && !trigger_ff) begin
        // Fresh start: restart the step timer so the first step is a full interval
        trigger_ff  <= 1'b1;                                          // see R2
        tick_cnt_ff <= 9'h000;
        step_cnt_ff <= 7'h00;
      end else if (trigger_ff) begin
        if (immediate) begin
          o_core_buck_a_code <= target_a_ff;                          // see R6
          o_core_buck_b_code <= target_b_ff;
          trigger_ff         <= start;                                // see R3
        end else if (at_target) begin
          // A new start in the completing cycle wins over the self-clear
          trigger_ff <= start;                                        // see R3
        end else begin
          tick_cnt_ff <= base_tick ? 9'h000 : tick_cnt_ff + 9'h001;
          if (base_tick) begin
            step_cnt_ff <= step_due ? 7'h00 : step_cnt_ff + 7'h01;
          end
          if (step_due) begin
            o_core_buck_a_code <= step_toward(o_core_buck_a_code, target_a_ff); // see R14
            o_core_buck_b_code <= step_toward(o_core_buck_b_code, target_b_ff); // see R7
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Monitor blanking after set-point writes
  // ----------------------------------------
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      bb_blank_ff <= 20'h0_0000;
      lr_blank_ff <= 20'h0_0000;
    end else begin
      // Each accepted write restarts the full window
      if (wr_bb) begin
        bb_blank_ff <= BLANK_CYCLES[19:0];                            // see R12
      end else if (bb_blank_ff != 20'h0_0000) begin
        bb_blank_ff <= bb_blank_ff - 20'h0_0001;
      end
      if (wr_lr) begin
        lr_blank_ff <= BLANK_CYCLES[19:0];                            // see R9
      end else if (lr_blank_ff != 20'h0_0000) begin
        lr_blank_ff <= lr_blank_ff - 20'h0_0001;
      end
    end
  end

  // ----------------------------------------
  // Voltage decode and rail code outputs
  // ----------------------------------------
  // Two-slope tables: 25 mV steps below the knee, 50 mV above
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_buckboost_code     <= `RST_BUCKBOOST_CODE;
      o_buckboost_mv       <= 12'h000;
      o_buckboost_reserved <= 1'b0;
      o_linear_code        <= `RST_LINEAR_CODE;
      o_linear_mv          <= 12'h000;
    end else begin
      o_buckboost_code     <= bb_code_ff;
      o_buckboost_reserved <= (bb_code_ff > `BB_MAX_CODE);            // see R1
      if (bb_code_ff > `BB_MAX_CODE) begin
        o_buckboost_mv <= 12'h000;
      end else if (bb_code_ff <= `BB_KNEE_CODE) begin
        o_buckboost_mv <= `BB_BASE_MV + `FINE_STEP_MV * {6'h00, bb_code_ff};
      end else begin
        o_buckboost_mv <= `BB_KNEE_MV + `COARSE_STEP_MV * {6'h00, bb_code_ff - `BB_KNEE_CODE};
      end
      o_linear_code <= lr_code_ff;
      if (lr_code_ff <= `LR_KNEE_CODE) begin
        o_linear_mv <= `LR_BASE_MV + `FINE_STEP_MV * {6'h00, lr_code_ff};   // see R11
      end else begin
        o_linear_mv <= `LR_KNEE_MV + `COARSE_STEP_MV * {6'h00, lr_code_ff - `LR_KNEE_CODE};
      end
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // Registered one cycle after the read strobe; unmapped addresses read zero
  always @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `ADDR_RAMP_CTRL:   o_reg_rdata <= {trigger_ff, auto_apply_ff, 3'b000, rate_ff}; // see R15
        `ADDR_LINEAR_REG:  o_reg_rdata <= {2'b00, lr_code_ff};                          // see R11
        `ADDR_BUCKBOOST:   o_reg_rdata <= {skip_bb_ff, 1'b0, bb_code_ff};
        `ADDR_CORE_BUCK_A: o_reg_rdata <= {skip_a_ff, 1'b0, target_a_ff};
        `ADDR_CORE_BUCK_B: o_reg_rdata <= {skip_b_ff, 1'b0, target_b_ff};
        default:           o_reg_rdata <= 8'h00;
      endcase
    end
  end

endmodule // rail_setpoint_ramp_control

// ### rail_ramp_asserts.sv
// Checker for rail set-point decode, monitor blanking and core ramping.
// Assumes it is bound to the rail control top and sees only its ports.
`timescale 1ns/1ps
module rail_ramp_asserts #(
  parameter BLANK_CYCLES = 20  // Blank length in clocks
) (
  input wire        i_ref_clk,
  input wire        i_reset_n,
  input wire        i_reg_wr,
  input wire        i_reg_rd,
  input wire [7:0]  i_reg_addr,
  input wire [7:0]  i_reg_wdata,
  input wire        i_unlock,
  input wire [7:0]  o_reg_rdata,
  input wire [5:0]  o_core_buck_a_code,
  input wire [5:0]  o_buckboost_code,
  input wire [11:0] o_buckboost_mv,
  input wire        o_buckboost_reserved,
  input wire [5:0]  o_linear_code,
  input wire [11:0] o_linear_mv,
  input wire        o_buckboost_monitor_blank,
  input wire        o_linear_monitor_blank,
  input wire        o_ramp_busy
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  // Accepted writes to the password-gated set-points
  wire lin_acc = i_reg_wr && i_reg_addr == 8'h1b && i_unlock;
  wire bb_acc  = i_reg_wr && i_reg_addr == 8'h19 && i_unlock;
  // Shadow of the rate field; rate 7 jumps, so step size is not judged there
  reg  [2:0] rate_ff;
  always @(posedge i_ref_clk or negedge i_reset_n)
    if (!i_reset_n) rate_ff <= 3'h6;
    else if (i_reg_wr && i_reg_addr == 8'h1a) rate_ff <= i_reg_wdata[2:0];

  chk_bb_reserved_flag: assert property (o_buckboost_reserved == (o_buckboost_code > 6'h34))
    else $error("Buck-boost reserved flag wrong");
  chk_bb_mv_decode: assert property ($past(i_reset_n) |-> o_buckboost_mv == (o_buckboost_reserved ? 12'h000 :
    o_buckboost_code <= 6'h0f ? 12'd1175 + 12'd25 * o_buckboost_code : 12'd1550 + 12'd50 * (o_buckboost_code - 6'h0f)))
    else $error("Buck-boost millivolts wrong");
  chk_lin_mv_decode: assert property ($past(i_reset_n) |-> o_linear_mv == (o_linear_code <= 6'h1a ?
    12'd900 + 12'd25 * o_linear_code : 12'd1550 + 12'd50 * (o_linear_code - 6'h1a)))
    else $error("Linear regulator millivolts wrong");
  chk_lin_blank_hold: assert property (lin_acc |=> o_linear_monitor_blank [*8])
    else $error("Linear blanking too short");
  chk_bb_blank_end: assert property ($fell(o_buckboost_monitor_blank) |-> $past(bb_acc, BLANK_CYCLES + 1))
    else $error("Buck-boost blanking length wrong");
  chk_locked_write_ignored: assert property (i_reg_wr && i_reg_addr == 8'h1b && !i_unlock &&
    !o_linear_monitor_blank |=> !o_linear_monitor_blank)
    else $error("Locked write started blanking");
  chk_trigger_busy: assert property (i_reg_wr && i_reg_addr == 8'h1a && i_reg_wdata[7] |=> o_ramp_busy)
    else $error("Trigger did not raise busy");
  chk_core_hold_idle: assert property ($changed(o_core_buck_a_code) |-> $past(o_ramp_busy))
    else $error("Core code moved without a ramp");
  chk_step_one_code: assert property ($changed(o_core_buck_a_code) && rate_ff != 3'h7 |->
    o_core_buck_a_code == $past(o_core_buck_a_code) + 6'h01 || o_core_buck_a_code == $past(o_core_buck_a_code) - 6'h01)
    else $error("Core step not one code");
  chk_rate_rsvd_zero: assert property (i_reg_rd && i_reg_addr == 8'h1a |=> o_reg_rdata[5:3] == 3'h0)
    else $error("Ramp control reserved bits not zero");

  cov_reserved: cover property (o_buckboost_reserved);
  cov_ramp: cover property ($rose(o_ramp_busy));
  cov_blank: cover property ($fell(o_linear_monitor_blank));
endmodule // rail_ramp_asserts

// ### host_model.sv
// Host model driving the register strobes of the rail control block.
// Assumes the block samples strobes on the rising clock edge.
`timescale 1ns/1ps
module host_model (
  output reg        o_reg_wr,
  output reg        o_reg_rd,
  output reg  [7:0] o_reg_addr,
  output reg  [7:0] o_reg_wdata,
  output reg        o_unlock,
  input  wire       i_ref_clk,
  input  wire [7:0] i_reg_rdata
);
  // Idle bus at time zero, password not yet given
  initial begin
    o_reg_wr = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'h00;
    o_reg_wdata = 8'h00;
    o_unlock = 1'b0;
  end
  // One-cycle write; released lines flip so stale values never look valid
  task automatic wr(input [7:0] a, input [7:0] d);
    @(negedge i_ref_clk);
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = d;
    @(negedge i_ref_clk);
    o_reg_wr = 1'b0;
    o_reg_addr = ~a;
    o_reg_wdata = ~d;
  endtask
  // One-cycle read; data is registered and taken one edge later
  task automatic rd(input [7:0] a, output [7:0] d);
    @(negedge i_ref_clk);
    o_reg_rd = 1'b1;
    o_reg_addr = a;
    @(negedge i_ref_clk);
    o_reg_rd = 1'b0;
    o_reg_addr = ~a;
    d = i_reg_rdata;
  endtask
  // Password state as the unlock logic would present it
  task automatic lock(input v);
    @(negedge i_ref_clk);
    o_unlock = v;
  endtask
endmodule // host_model

// ### tb_top.sv
// Testbench for the rail set-point and ramp control block.
// Assumes the host model drives every input except clock and reset.
`timescale 1ns/1ps
module tb_top;
  reg         i_ref_clk, i_reset_n;
  wire        wr, rd, unlock, skip_a, skip_b, bb_skip, bb_rsv, bb_blank, lin_blank, busy;
  wire [7:0]  addr, wdata, rdata;
  wire [5:0]  code_a, code_b, bb_code, lin_code;
  wire [11:0] bb_mv, lin_mv;
  integer     err_count, check_count, n, c, e;

  host_model u_host_model (.o_reg_wr(wr), .o_reg_rd(rd), .o_reg_addr(addr), .o_reg_wdata(wdata),
    .o_unlock(unlock), .i_ref_clk(i_ref_clk), .i_reg_rdata(rdata));
  rail_setpoint_ramp_control #(.BLANK_CYCLES(20)) u_rail_setpoint_ramp_control (.i_ref_clk(i_ref_clk),
    .i_reset_n(i_reset_n), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_unlock(unlock), .o_reg_rdata(rdata), .o_core_buck_a_code(code_a), .o_core_buck_b_code(code_b),
    .o_core_buck_a_skip_en(skip_a), .o_core_buck_b_skip_en(skip_b), .o_buckboost_code(bb_code),
    .o_buckboost_mv(bb_mv), .o_buckboost_reserved(bb_rsv), .o_buckboost_skip_en(bb_skip),
    .o_linear_code(lin_code), .o_linear_mv(lin_mv), .o_buckboost_monitor_blank(bb_blank),
    .o_linear_monitor_blank(lin_blank), .o_ramp_busy(busy));

  task chk(input [11:0] seen, input [11:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task rdchk(input [7:0] a, input [7:0] x);
    reg [7:0] d;
    u_host_model.rd(a, d);
    chk({4'h0, d}, {4'h0, x});
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Bounded wait for the ramp to finish; n counts idle-wait cycles
  task wait_idle;
    n = 0;
    while (busy !== 1'b0 && n < 40000) begin
      @(negedge i_ref_clk);
      n = n + 1;
    end
    if (n >= 40000) begin
      err_count = err_count + 1;
      finish_test;
    end
  endtask

  task t_reset;
    rdchk(8'h1a, 8'h06);
    rdchk(8'h1b, 8'h1f);
    rdchk(8'h19, 8'hb2);
    rdchk(8'h30, 8'h00);
    chk(bb_mv, 12'd3300);
    chk(lin_mv, 12'd1800);
    chk({9'h0, skip_a, skip_b, bb_skip}, 12'h007);
  endtask
  task t_linear;
    u_host_model.wr(8'h1b, 8'h05);
    chk({11'h0, lin_blank}, 12'h000);
    rdchk(8'h1b, 8'h1f);
    u_host_model.wr(8'h19, 8'h05);
    chk({11'h0, bb_blank}, 12'h000);
    rdchk(8'h19, 8'hb2);
    u_host_model.lock(1'b1);
    u_host_model.wr(8'h1b, 8'hff);
    chk({11'h0, lin_blank}, 12'h001);
    rdchk(8'h1b, 8'h3f);
    chk({6'h0, lin_code}, 12'h03f);
    chk(lin_mv, 12'd3400);
    repeat (25) @(negedge i_ref_clk);
    chk({11'h0, lin_blank}, 12'h000);
  endtask
  // Every buck-boost code, reserved ones checked for the flag and a zero millivolt decode
  task t_buckboost;
    for (c = 0; c < 64; c = c + 1) begin
      u_host_model.wr(8'h19, {2'b10, c[5:0]});
      @(negedge i_ref_clk);
      e = (c <= 15) ? 1175 + 25 * c : (c <= 52) ? 1550 + 50 * (c - 15) : 0;
      chk(bb_mv, e[11:0]);
      chk({11'h0, bb_rsv}, {11'h0, c > 52});
      chk({11'h0, bb_blank}, 12'h001);
      chk({6'h0, bb_code}, {6'h0, c[5:0]});
      chk({11'h0, bb_skip}, 12'h001);
      chk({11'h0, busy}, 12'h000);
    end
  endtask
  task t_immediate;
    u_host_model.wr(8'h16, 8'h8a);
    chk({6'h0, code_a}, 12'h008);
    u_host_model.wr(8'h1a, 8'h87);
    wait_idle;
    chk({6'h0, code_a}, 12'h00a);
    chk({11'h0, n <= 4}, 12'h001);
  endtask
  task t_step;
    u_host_model.wr(8'h1a, 8'h3e);
    rdchk(8'h1a, 8'h06);
    u_host_model.wr(8'h16, 8'h08);
    u_host_model.wr(8'h17, 8'h09);
    u_host_model.wr(8'h1a, 8'h86);
    repeat (510) @(negedge i_ref_clk);
    chk({6'h0, code_a}, 12'h009);
    wait_idle;
    chk({11'h0, n + 510 >= 998 && n + 510 <= 1004}, 12'h001);
    chk({6'h0, code_a, code_b}, 12'h209);
    chk({10'h0, skip_a, skip_b}, 12'h000);
    rdchk(8'h1a, 8'h06);
  endtask
  task t_auto;
    u_host_model.wr(8'h1a, 8'h45);
    u_host_model.wr(8'h17, 8'h0b);
    chk({11'h0, busy}, 12'h001);
    wait_idle;
    chk({11'h0, n >= 1995 && n <= 2004}, 12'h001);
    chk({5'h0, skip_b, code_b}, 12'h00b);
    rdchk(8'h1a, 8'h45);
  endtask
  // One-code auto ramps at the slow rate codes; busy time follows the step interval
  task t_rates;
    for (c = 0; c < 5; c = c + 1) begin
      u_host_model.wr(8'h1a, 8'h40 | {5'h00, c[2:0]});
      u_host_model.wr(8'h17, {2'b00, 6'h0c + c[5:0]});
      wait_idle;
      e = (64 >> c) * 500 + 1;
      chk({11'h0, n >= e - 2 && n <= e + 2}, 12'h001);
      chk({6'h0, code_b}, 12'h00c + c[11:0]);
    end
  endtask

  initial begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_reset_n = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (20) @(negedge i_ref_clk);
    i_reset_n = 1'b1;
    t_reset;
    t_linear;
    t_buckboost;
    t_immediate;
    t_step;
    t_auto;
    t_rates;
    finish_test;
  end
endmodule // tb_top

bind rail_setpoint_ramp_control rail_ramp_asserts #(.BLANK_CYCLES(BLANK_CYCLES)) u_rail_ramp_asserts (
  .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_unlock(i_unlock), .o_reg_rdata(o_reg_rdata),
  .o_core_buck_a_code(o_core_buck_a_code), .o_buckboost_code(o_buckboost_code), .o_buckboost_mv(o_buckboost_mv),
  .o_buckboost_reserved(o_buckboost_reserved), .o_linear_code(o_linear_code), .o_linear_mv(o_linear_mv),
  .o_buckboost_monitor_blank(o_buckboost_monitor_blank), .o_linear_monitor_blank(o_linear_monitor_blank),
  .o_ramp_busy(o_ramp_busy));
